// [rtl/divider_phase_delay_select.sv]
`timescale 1ns/1ps
//
// Overview of operation
// R01: select strap picks phased output: secondary, primary, secondary high, primary high.
// R02: phase code equals low strap index plus four times high strap index.
// R03: after sync, each divider waits its offset in input cycles before first edge.
// R04: offset equal to divide ratio aligns exactly like zero offset.
// R05: unique offsets lie below the divide ratio; offset never exceeds fifteen.
// R06: nonzero ratio-table phase overrides the strap phase code.
// R07: nonzero delay-mode strap turns secondary target into fine delay instead.
// R08: fine delay equals full scale times code over sixteen.
// R09: full scale is 1.5 ns, 5 ns or 10 ns.
// R10: configurer keeps delay below half the output period.
// R11: delay-mode strap at zero bypasses and powers down the delay element.
// R12: divide-by-one divider is bypassed and powered down.
// R13: an output set off powers down with its divider.
// R14: single-ended mode drives true clock and inverted copy on secondary pair.
// R15: four-level strap decodes to index 0, 1, 2, 3 from ground upward.
// R16: start-high option makes phased output begin high after sync.
module divider_phase_delay_select
    import clock_select_pkg::*;
#(
    parameter int unsigned MAX_DIVIDE = 32
)
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  sync_request,
    input  wire logic [LEVEL_W-1:0]    delay_mode_strap,
    input  wire logic [LEVEL_W-1:0]    phase_target_strap,
    input  wire logic [LEVEL_W-1:0]    phase_code_low_strap,
    input  wire logic [LEVEL_W-1:0]    phase_code_high_strap,
    input  wire logic [DIV_W-1:0]      primary_divide,
    input  wire logic [PHASE_W-1:0]    primary_table_phase,
    input  wire logic                  primary_off,
    input  wire logic [DIV_W-1:0]      secondary_divide,
    input  wire logic [PHASE_W-1:0]    secondary_table_phase,
    input  wire logic                  secondary_off,
    input  wire logic                  single_ended_mode,
    output logic                       primary_clock_out,
    output logic                       primary_divider_down,
    output logic                       primary_bypass,
    output logic                       secondary_clock_out,
    output logic                       secondary_clock_out_comp,
    output logic                       secondary_divider_down,
    output logic                       secondary_bypass,
    output logic                       secondary_single_ended,
    output logic                       delay_bypass,
    output logic [PHASE_W-1:0]         delay_step,
    output logic [DELAY_PS_W-1:0]      delay_full_scale_ps,
    output logic [DELAY_PS_W-1:0]      delay_ps
);

    localparam int unsigned PIN_W = 1 + 4 * LEVEL_W + 2 * (DIV_W + PHASE_W + 1) + 1;

    if (MAX_DIVIDE < 2 || MAX_DIVIDE > (2 ** DIV_W) - 1)
    begin : g_bad_divide
        $error("MAX_DIVIDE outside the range the divider counter can serve");
    end

    typedef struct packed {
        logic [PIN_W-1:0]      meta;
        logic [PIN_W-1:0]      pins;
        logic                  sync_prev;
        logic [DIV_W-1:0]      p_div;
        logic [PHASE_W-1:0]    p_phase;
        logic                  p_high;
        logic                  p_en;
        logic [DIV_W-1:0]      s_div;
        logic [PHASE_W-1:0]    s_phase;
        logic                  s_high;
        logic                  s_en;
        logic                  p_byp;
        logic                  s_byp;
        logic                  se;
        logic                  d_byp;
        logic [PHASE_W-1:0]    d_step;
        logic [DELAY_PS_W-1:0] fs_ps;
        logic [DELAY_PS_W-1:0] d_ps;
    } top_reg_type;

    top_reg_type q;
    top_reg_type d;

    logic [PIN_W-1:0]       pins_raw;
    logic                   sync_s;
    logic [INDEX_W-1:0]     mode_idx;
    logic [INDEX_W-1:0]     target_idx;
    logic [PHASE_W-1:0]     code;
    logic [DIV_W-1:0]       p_div_s;
    logic [DIV_W-1:0]       s_div_s;
    logic [PHASE_W-1:0]     p_tab_s;
    logic [PHASE_W-1:0]     s_tab_s;
    logic                   p_off_s;
    logic                   s_off_s;
    logic                   se_s;
    logic                   p_target;
    logic                   s_target;
    logic [2*DELAY_PS_W-1:0] product;

    assign pins_raw = {sync_request, delay_mode_strap, phase_target_strap,
                       phase_code_low_strap, phase_code_high_strap,
                       primary_divide, primary_table_phase, primary_off,
                       secondary_divide, secondary_table_phase, secondary_off,
                       single_ended_mode};

    // all fields read only from the second synchroniser stage
    assign {sync_s, mode_idx, target_idx, code, p_div_s, p_tab_s, p_off_s,
            s_div_s, s_tab_s, s_off_s, se_s} =
           {q.pins[PIN_W-1],
            strap_index(q.pins[PIN_W-2 -: LEVEL_W]), // [R15]
            strap_index(q.pins[PIN_W-2-LEVEL_W -: LEVEL_W]),
            strap_index(q.pins[PIN_W-2-3*LEVEL_W -: LEVEL_W]), // [R02]
            strap_index(q.pins[PIN_W-2-2*LEVEL_W -: LEVEL_W]),
            q.pins[PIN_W-2-4*LEVEL_W:0]};

    // primary phased only for the one-third and full levels
    assign p_target = target_idx[0]; // [R01]
    assign s_target = !target_idx[0];
    assign product  = (2*DELAY_PS_W)'(q.fs_ps) * (2*DELAY_PS_W)'(q.d_step);

    always_comb
    begin
        d           = q;
        d.meta      = pins_raw;
        d.pins      = q.meta;
        d.sync_prev = sync_s;
        d.p_div     = p_div_s;
        d.s_div     = s_div_s;
        d.p_en      = !p_off_s && p_div_s != '0 && p_div_s <= DIV_W'(MAX_DIVIDE); // [R13]
        d.s_en      = !s_off_s && s_div_s != '0 && s_div_s <= DIV_W'(MAX_DIVIDE);
        d.p_byp     = d.p_en && p_div_s == DIVIDE_BYPASS; // [R12]
        d.s_byp     = d.s_en && s_div_s == DIVIDE_BYPASS;
        d.p_high    = p_target && target_idx[1]; // [R01] [R16]
        d.s_high    = s_target && target_idx[1];
        d.se        = se_s;
        d.d_byp     = mode_idx == LEVEL_GND; // [R11]
        d.p_phase   = (p_target && p_tab_s == '0) ? code : p_tab_s; // [R06]
        d.s_phase   = (s_target && d.d_byp && s_tab_s == '0) ? code : s_tab_s; // [R07]
        d.d_step    = (s_target && !d.d_byp && d.s_en) ? code : '0; // [R07] [R08]
        unique case (mode_idx)
            LEVEL_GND:      d.fs_ps = '0;
            LEVEL_THIRD:    d.fs_ps = FS_SHORT_PS; // [R09]
            LEVEL_TWOTHIRD: d.fs_ps = FS_MID_PS;
            LEVEL_FULL:     d.fs_ps = FS_LONG_PS;
        endcase
        d.d_ps      = product[FINE_SHIFT +: DELAY_PS_W]; // [R08]
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    divider_link_if prim_link ();
    divider_link_if sec_link ();

    assign prim_link.divide     = q.p_div;
    assign prim_link.phase      = q.p_phase;
    assign prim_link.start_high = q.p_high;
    assign prim_link.enable     = q.p_en;
    assign prim_link.sync_pulse = sync_s && !q.sync_prev; // [R03]
    assign sec_link.divide      = q.s_div;
    assign sec_link.phase       = q.s_phase;
    assign sec_link.start_high  = q.s_high;
    assign sec_link.enable      = q.s_en;
    assign sec_link.sync_pulse  = sync_s && !q.sync_prev;

    divider_channel u_primary (
        .clk  (clk),
        .rst  (rst),
        .link (prim_link.chan)
    );

    divider_channel u_secondary (
        .clk  (clk),
        .rst  (rst),
        .link (sec_link.chan)
    );

    // bypassed path is an analog mux outside; the divider output idles low then
    assign primary_clock_out        = prim_link.clk_out;
    assign primary_divider_down     = prim_link.powered_down;
    assign primary_bypass           = q.p_byp;
    assign secondary_clock_out      = sec_link.clk_out;
    assign secondary_clock_out_comp = sec_link.clk_out_n; // [R14]
    assign secondary_divider_down   = sec_link.powered_down;
    assign secondary_bypass         = q.s_byp;
    assign secondary_single_ended   = q.se;
    assign delay_bypass             = q.d_byp;
    assign delay_step               = q.d_step;
    assign delay_full_scale_ps      = q.fs_ps;
    assign delay_ps                 = q.d_ps;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_delay_off: assert property (mode_idx == LEVEL_GND |=> delay_bypass ##1 // [R11]
        delay_ps == '0)
        else $error("delay element not bypassed at mode zero");
    a_target_code: assert property (p_target && p_tab_s == '0 |=> // [R01] [R02]
        q.p_phase == $past(code))
        else $error("primary phase not strap code");
    a_table_override: assert property (p_tab_s != '0 |=> q.p_phase == $past(p_tab_s)) // [R06]
        else $error("table phase did not override");
    a_fine_scale: assert property (!delay_bypass |=> // [R08]
        delay_ps == DELAY_PS_W'(((2*DELAY_PS_W)'($past(q.fs_ps)) * $past(q.d_step))
        >> FINE_SHIFT))
        else $error("fine delay not scaled by sixteenths");
    a_delay_phase: assert property (s_target && mode_idx != LEVEL_GND // [R07]
        && s_tab_s == '0 |=> q.s_phase == '0)
        else $error("delay mode still applied cycle offset");

    c_delay_used: cover property (!delay_bypass && delay_step == MAX_PHASE);

endmodule : divider_phase_delay_select

// [rtl/clock_select_pkg.sv]
package clock_select_pkg;

    localparam int unsigned DIV_W       = 6;
    localparam int unsigned PHASE_W     = 4;
    localparam int unsigned LEVEL_W     = 3;
    localparam int unsigned INDEX_W     = 2;
    localparam int unsigned DELAY_PS_W  = 14;
    localparam int unsigned FINE_SHIFT  = 4;
    localparam int unsigned PHASE_STEPS = 16;

    localparam logic [DIV_W-1:0]   DIVIDE_BYPASS = 6'h01;
    localparam logic [PHASE_W-1:0] MAX_PHASE     = 4'hf;

    // strap level indices
    localparam logic [INDEX_W-1:0] LEVEL_GND      = 2'h0;
    localparam logic [INDEX_W-1:0] LEVEL_THIRD    = 2'h1;
    localparam logic [INDEX_W-1:0] LEVEL_TWOTHIRD = 2'h2;
    localparam logic [INDEX_W-1:0] LEVEL_FULL     = 2'h3;

    // full-scale delay ranges, picosecond
    localparam logic [DELAY_PS_W-1:0] FS_SHORT_PS = 14'h05dc;
    localparam logic [DELAY_PS_W-1:0] FS_MID_PS   = 14'h1388;
    localparam logic [DELAY_PS_W-1:0] FS_LONG_PS  = 14'h2710;

    // thermometer comparator word to level index; counting ones tolerates bubbles
    function automatic logic [INDEX_W-1:0] strap_index(input logic [LEVEL_W-1:0] thermo);
        logic [INDEX_W-1:0] n;
        n = '0;
        for (int i = 0; i < int'(LEVEL_W); i++)
        begin
            n = n + INDEX_W'(thermo[i]);
        end
        return n;
    endfunction : strap_index

endpackage : clock_select_pkg

// [rtl/divider_link_if.sv]
`timescale 1ns/1ps
interface divider_link_if;
    import clock_select_pkg::*;
    logic [DIV_W-1:0]   divide;
    logic [PHASE_W-1:0] phase;
    logic               start_high;
    logic               enable;
    logic               sync_pulse;
    logic               clk_out;
    logic               clk_out_n;
    logic               powered_down;

    modport cfg  (output divide, phase, start_high, enable, sync_pulse,
                  input  clk_out, clk_out_n, powered_down);
    modport chan (input  divide, phase, start_high, enable, sync_pulse,
                  output clk_out, clk_out_n, powered_down);
endinterface : divider_link_if

// [rtl/divider_channel.sv]
`timescale 1ns/1ps
module divider_channel
    import clock_select_pkg::*;
(
    input wire logic     clk,
    input wire logic     rst,
    divider_link_if.chan link
);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} chan_state_type;

    typedef struct packed {
        chan_state_type   st;
        logic [DIV_W-1:0] cnt;
        logic             out;
        logic             out_n;
        logic             pd;
    } chan_reg_type;

    localparam chan_reg_type CHAN_RESET = '{st: ST_IDLE, cnt: '0, out: 1'b0, out_n: 1'b0,
                                            pd: 1'b1};

    chan_reg_type     q;
    chan_reg_type     d;
    logic             active;
    logic [DIV_W-1:0] eff_phase;

    // offset folded into one period so phase == divide aligns like zero
    function automatic logic [DIV_W-1:0] phase_mod(input logic [PHASE_W-1:0] ph,
                                                   input logic [DIV_W-1:0]   dv);
        logic [DIV_W-1:0] r;
        r = DIV_W'(ph);
        for (int i = 0; i < int'(PHASE_STEPS); i++)
        begin
            if (dv != '0 && r >= dv)
            begin
                r = r - dv;
            end
        end
        return r;
    endfunction : phase_mod

    // odd ratios give the shorter half to the high time
    function automatic logic [DIV_W-1:0] seg_last(input logic lvl, input logic [DIV_W-1:0] dv);
        logic [DIV_W-1:0] hi;
        hi = dv >> 1;
        return lvl ? (hi - DIV_W'(1)) : (dv - hi - DIV_W'(1));
    endfunction : seg_last

    assign active    = link.enable && (link.divide > DIVIDE_BYPASS);
    assign eff_phase = phase_mod(link.phase, link.divide); // [R04] [R05]

    always_comb
    begin
        d = q;
        if (!active)
        begin
            d = CHAN_RESET; // [R12] [R13]
        end
        else if (link.sync_pulse)
        begin
            d.st    = ST_WAIT; // [R03]
            d.cnt   = eff_phase;
            d.out   = link.start_high; // [R16]
            d.out_n = ~link.start_high;
            d.pd    = 1'b0;
        end
        else
        begin
            d.pd = 1'b0;
            unique case (q.st)
                ST_IDLE:
                begin
                    d.out   = link.start_high;
                    d.out_n = ~link.start_high;
                end
                ST_WAIT, ST_RUN:
                begin
                    if (q.cnt == '0)
                    begin
                        d.st    = ST_RUN; // [R03]
                        d.out   = ~q.out;
                        d.out_n = q.out; // [R14]
                        d.cnt   = seg_last(~q.out, link.divide);
                    end
                    else
                    begin
                        d.cnt = q.cnt - DIV_W'(1);
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= CHAN_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.clk_out      = q.out;
    assign link.clk_out_n    = q.out_n;
    assign link.powered_down = q.pd;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sync_start_level: assert property (active && link.sync_pulse |=> // [R03] [R16]
        q.st == ST_WAIT && q.out == $past(link.start_high) && q.cnt == $past(eff_phase))
        else $error("sync did not load start level and offset");
    a_wait_edge: assert property (active && !link.sync_pulse && q.st == ST_WAIT // [R03]
        && q.cnt == '0 |=> q.st == ST_RUN && q.out != $past(q.out))
        else $error("first edge missing after offset");
    a_wait_hold: assert property (active && !link.sync_pulse && q.st == ST_WAIT // [R03]
        && q.cnt != '0 |=> q.out == $past(q.out) && q.cnt == $past(q.cnt) - DIV_W'(1))
        else $error("output moved during offset wait");
    a_phase_wrap: assert property (active && link.sync_pulse // [R04]
        && DIV_W'(link.phase) == link.divide |=> q.cnt == '0)
        else $error("offset equal to ratio not folded to zero");
    a_phase_unique: assert property (q.st == ST_WAIT |-> q.cnt < link.divide) // [R05]
        else $error("offset wait exceeds one period");
    a_bypass_down: assert property (link.divide == DIVIDE_BYPASS |=> // [R12]
        q.pd && !q.out && q.st == ST_IDLE)
        else $error("divide by one not powered down");
    a_off_down: assert property (!link.enable |=> q.pd && !q.out && !q.out_n) // [R13]
        else $error("disabled output still active");
    a_comp_inverse: assert property (!q.pd |-> q.out_n == !q.out) // [R14]
        else $error("complement pin not inverted");

    c_offset_sync: cover property (active && link.sync_pulse && eff_phase != '0);
    c_start_high:  cover property (active && link.sync_pulse && link.start_high);
    c_wrap_phase:  cover property (active && link.sync_pulse && link.phase != '0
                                   && eff_phase == '0);
    c_running:     cover property (q.st == ST_RUN ##1 q.st == ST_RUN);

endmodule : divider_channel

// [sim/strap_board_model.sv]
`timescale 1ns/1ps
module strap_board_model
    import clock_select_pkg::*;
(
    input  wire logic [INDEX_W-1:0] mode_idx,
    input  wire logic [INDEX_W-1:0] target_idx,
    input  wire logic [INDEX_W-1:0] low_idx,
    input  wire logic [INDEX_W-1:0] high_idx,
    output logic      [LEVEL_W-1:0] delay_mode_strap,
    output logic      [LEVEL_W-1:0] phase_target_strap,
    output logic      [LEVEL_W-1:0] phase_code_low_strap,
    output logic      [LEVEL_W-1:0] phase_code_high_strap
);
    // a strap at level n trips the n lowest comparators of the ladder
    function automatic logic [LEVEL_W-1:0] level_word(input logic [INDEX_W-1:0] idx);
        logic [LEVEL_W-1:0] w;
        for (int i = 0; i < int'(LEVEL_W); i++)
        begin
            w[i] = (i < int'(idx));
        end
        return w;
    endfunction : level_word

    always_comb
    begin
        delay_mode_strap      = level_word(mode_idx);
        phase_target_strap    = level_word(target_idx);
        phase_code_low_strap  = level_word(low_idx);
        phase_code_high_strap = level_word(high_idx);
    end
endmodule : strap_board_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import clock_select_pkg::*;
    logic                  clk, rst, sync_request, primary_off, secondary_off, single_ended_mode;
    logic [INDEX_W-1:0]    mode_idx, target_idx, low_idx, high_idx;
    logic [LEVEL_W-1:0]    delay_mode_strap, phase_target_strap;
    logic [LEVEL_W-1:0]    phase_code_low_strap, phase_code_high_strap;
    logic [DIV_W-1:0]      primary_divide, secondary_divide;
    logic [PHASE_W-1:0]    primary_table_phase, secondary_table_phase, delay_step;
    logic                  primary_clock_out, primary_divider_down, primary_bypass;
    logic                  secondary_clock_out, secondary_clock_out_comp;
    logic                  secondary_divider_down, secondary_bypass, secondary_single_ended;
    logic                  delay_bypass;
    logic [DELAY_PS_W-1:0] delay_full_scale_ps, delay_ps, fs_exp;
    int                    err_count, comparisons, pr, sr;
    logic                  p0, s0;

    strap_board_model board (.mode_idx(mode_idx), .target_idx(target_idx), .low_idx(low_idx),
        .high_idx(high_idx), .delay_mode_strap(delay_mode_strap),
        .phase_target_strap(phase_target_strap), .phase_code_low_strap(phase_code_low_strap),
        .phase_code_high_strap(phase_code_high_strap));

    divider_phase_delay_select #(.MAX_DIVIDE(32)) dut (.clk(clk), .rst(rst),
        .sync_request(sync_request), .delay_mode_strap(delay_mode_strap),
        .phase_target_strap(phase_target_strap), .phase_code_low_strap(phase_code_low_strap),
        .phase_code_high_strap(phase_code_high_strap), .primary_divide(primary_divide),
        .primary_table_phase(primary_table_phase), .primary_off(primary_off),
        .secondary_divide(secondary_divide), .secondary_table_phase(secondary_table_phase),
        .secondary_off(secondary_off), .single_ended_mode(single_ended_mode),
        .primary_clock_out(primary_clock_out), .primary_divider_down(primary_divider_down),
        .primary_bypass(primary_bypass), .secondary_clock_out(secondary_clock_out),
        .secondary_clock_out_comp(secondary_clock_out_comp),
        .secondary_divider_down(secondary_divider_down), .secondary_bypass(secondary_bypass),
        .secondary_single_ended(secondary_single_ended), .delay_bypass(delay_bypass),
        .delay_step(delay_step), .delay_full_scale_ps(delay_full_scale_ps),
        .delay_ps(delay_ps));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            err_count++;
            $display("BAD t=%0t seen %0h expected %0h", $time, seen, expected);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // pins pass two flops before the config registers, delay word one more
    task automatic set_cfg(input logic [DIV_W-1:0] dv, input logic [INDEX_W-1:0] lo,
                           input logic [INDEX_W-1:0] hi, input logic [INDEX_W-1:0] tg,
                           input logic [INDEX_W-1:0] md, input logic [PHASE_W-1:0] tp);
        @(posedge clk);
        primary_divide      <= dv;
        secondary_divide    <= dv;
        low_idx             <= lo;
        high_idx            <= hi;
        target_idx          <= tg;
        mode_idx            <= md;
        primary_table_phase <= tp;
        repeat (6) @(posedge clk);
        #1;
    endtask : set_cfg

    // k counts edges from the one that loads the start level; -1 means never high
    task automatic measure;
        @(posedge clk);
        sync_request <= 1'b1;
        pr = -1;
        sr = -1;
        repeat (3) @(posedge clk);
        #1;
        p0 = primary_clock_out;
        s0 = secondary_clock_out;
        for (int k = 0; k < 70; k++)
        begin
            if (pr < 0 && primary_clock_out === 1'b1) pr = k;
            if (sr < 0 && secondary_clock_out === 1'b1) sr = k;
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        sync_request <= 1'b0;
    endtask : measure

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        logic [DIV_W-1:0]   dv[7]  = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h04, 6'h10, 6'h08};
        logic [INDEX_W-1:0] lo[7]  = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h1};
        logic [INDEX_W-1:0] hi[7]  = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h3, 2'h1};
        logic [PHASE_W-1:0] tp[7]  = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2};
        int                 ex[7]  = '{0, 3, 7, 0, 0, 15, 2};
        logic [DELAY_PS_W-1:0] fs[4] = '{14'h0000, FS_SHORT_PS, FS_MID_PS, FS_LONG_PS};
        err_count = 0;
        comparisons = 0;
        rst = 1'b1;
        sync_request = 1'b0;
        {mode_idx, target_idx, low_idx, high_idx} = '0;
        primary_divide = 6'h08;
        secondary_divide = 6'h08;
        primary_table_phase = 4'h0;
        secondary_table_phase = 4'h0;
        primary_off = 1'b0;
        secondary_off = 1'b0;
        single_ended_mode = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // primary phased by strap code or ratio-table phase, secondary at zero
        for (int i = 0; i < 7; i++)
        begin
            set_cfg(dv[i], lo[i], hi[i], 2'h1, 2'h0, tp[i]);
            measure();
            check(sr, 1);
            check(pr - sr, ex[i]);
        end
        set_cfg(6'h08, 2'h3, 2'h0, 2'h0, 2'h0, 4'h0);
        measure();
        check(sr - pr, 3);
        set_cfg(6'h08, 2'h3, 2'h0, 2'h2, 2'h0, 4'h0);
        measure();
        check({p0, s0}, 2'b01);
        set_cfg(6'h08, 2'h3, 2'h0, 2'h3, 2'h0, 4'h0);
        measure();
        check({p0, s0}, 2'b10);
        // divide 8 gives an 80 ns period, so every delay tried stays under half
        for (int m = 0; m < 4; m++)
        begin
            set_cfg(6'h08, 2'h1, 2'h2, 2'h0, m[INDEX_W-1:0], 4'h0);
            fs_exp = fs[m];
            check(delay_full_scale_ps, fs_exp);
            check(delay_bypass, m == 0);
            check(delay_step, (m == 0) ? 0 : 9);
            check(delay_ps, (m == 0) ? 0 : (fs_exp * 9) / 16);
        end
        set_cfg(6'h08, 2'h3, 2'h0, 2'h0, 2'h2, 4'h0);
        measure();
        check(pr - sr, 0);
        set_cfg(6'h08, 2'h3, 2'h0, 2'h1, 2'h2, 4'h0);
        check(delay_step, 0);
        set_cfg(6'h01, 2'h0, 2'h0, 2'h1, 2'h0, 4'h0);
        check({primary_bypass, primary_divider_down}, 2'b11);
        check({secondary_bypass, secondary_single_ended}, 2'b10);
        measure();
        check(pr, -1);
        @(posedge clk);
        secondary_off <= 1'b1;
        single_ended_mode <= 1'b1;
        set_cfg(6'h04, 2'h0, 2'h0, 2'h1, 2'h0, 4'h0);
        check({secondary_divider_down, secondary_clock_out_comp}, 2'b10);
        measure();
        check(sr, -1);
        check(primary_divider_down, 0);
        @(posedge clk);
        secondary_off <= 1'b0;
        set_cfg(6'h04, 2'h0, 2'h0, 2'h1, 2'h0, 4'h0);
        measure();
        check(secondary_single_ended, 1);
        repeat (8)
        begin
            @(posedge clk);
            #1;
            check(secondary_clock_out_comp, !secondary_clock_out);
        end
        report_and_stop();
    end
endmodule : testbench
